// >>> logic/lcdtc_cfg_if.sv
// settings and vertical status passed between top and vertical sequencer
`timescale 1ns/100ps
interface lcdtc_cfg_if;
  logic                enable;
  logic                tft;
  logic                toggle_sel;
  logic [7:0]          toggle_val;
  logic [7:0]          back_porch;
  logic [7:0]          front_porch;
  logic [5:0]          sync_width;
  logic [9:0]          line_count;
  logic                line_tick;
  logic [9:0]          line_counter;
  lcdtc_pkg::lcdtc_vstate_e vstate;
  logic                ac_bias;
  modport ctl  (output enable, tft, toggle_sel, toggle_val, back_porch, front_porch,
                sync_width, line_count, line_tick,
                input line_counter, vstate, ac_bias);
  modport vert (input enable, tft, toggle_sel, toggle_val, back_porch, front_porch,
                sync_width, line_count, line_tick,
                output line_counter, vstate, ac_bias);
endinterface

// >>> logic/lcdtc_panel_timing.sv
// top of the lcd panel timing control block with its apb register file
//
// Local design decision: the APB slave port.
`timescale 1ns/100ps
module lcdtc_panel_timing #(
  parameter logic [11:0] H_ACTIVE = 12'h140,
  parameter logic [11:0] H_TOTAL  = 12'h150,
  parameter logic [11:0] H_SHIFT  = 12'h0A8
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             pixel_clock,
  output logic             horiz_sampling_clock,
  output logic             horiz_start_pulse,
  output logic             source_load_pulse,
  output logic             vertical_shift_clock,
  output logic             vertical_start_pulse,
  output logic             ac_bias_signal,
  output logic             video_data_enable,
  output logic             panel_power_pin,
  output logic             tft_mode,
  output logic [4:0]       pixel_bits
);
  // ******************************************************
  // apb decode
  // ******************************************************
  logic [31:0] ctrl1_reg;
  logic [31:0] ctrl2_reg;
  logic [31:0] ctrl4_reg;
  logic [31:0] ctrl5_reg;
  logic [31:0] rd_mux;
  logic [31:0] ctrl1_view;
  logic [11:0] h_cnt_reg;
  logic        sel1;
  logic        sel2;
  logic        sel4;
  logic        sel5;
  logic        mapped;
  logic        wr_en;
  logic        rd_setup;
  logic        voe;
  logic        pwen;
  logic        pwflip;
  logic        pix_rise;
  logic        vactive;
  logic        h_first;
  logic        h_last;
  logic        stn_first;

  lcdtc_cfg_if cfg ();

  assign sel1 = paddr == lcdtc_pkg::ADDR_CTRL1;
  assign sel2 = paddr == lcdtc_pkg::ADDR_CTRL2;
  assign sel4 = paddr == lcdtc_pkg::ADDR_CTRL4;
  assign sel5 = paddr == lcdtc_pkg::ADDR_CTRL5;
  assign mapped = sel1 | sel2 | sel4 | sel5;
  assign wr_en = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // line counter field is live status, not storage
  assign ctrl1_view = ctrl1_reg
                    | ({22'h000000, cfg.line_counter} << lcdtc_pkg::LCNT_LSB);
  assign rd_mux = sel1 ? ctrl1_view :
                  sel2 ? ctrl2_reg  :
                  sel4 ? ctrl4_reg  :
                  sel5 ? ctrl5_reg  : lcdtc_pkg::RESET_WORD;

  // ******************************************************
  // registers
  // ******************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_reg <= lcdtc_pkg::RESET_WORD;
      ctrl2_reg <= lcdtc_pkg::RESET_WORD;
      ctrl4_reg <= lcdtc_pkg::RESET_WORD;
      ctrl5_reg <= lcdtc_pkg::RESET_WORD;
    end else if (wr_en) begin
      if (sel1) ctrl1_reg <= pwdata & lcdtc_pkg::CTRL1_WMASK;
      if (sel2) ctrl2_reg <= pwdata;
      if (sel4) ctrl4_reg <= pwdata & lcdtc_pkg::CTRL4_WMASK;
      if (sel5) ctrl5_reg <= pwdata & lcdtc_pkg::CTRL5_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= lcdtc_pkg::RESET_WORD;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

  // ******************************************************
  // settings
  // ******************************************************
  assign voe    = ctrl1_reg[lcdtc_pkg::VOE_BIT];
  assign pwen   = ctrl5_reg[lcdtc_pkg::PWEN_BIT];
  assign pwflip = ctrl5_reg[lcdtc_pkg::PWFL_BIT];
  assign tft_mode = ctrl1_reg[lcdtc_pkg::PTYP_LSB +: lcdtc_pkg::PTYP_W]
                    == lcdtc_pkg::PTYP_TFT;
  assign pixel_bits = lcdtc_pkg::lcdtc_depth(tft_mode,
                        ctrl1_reg[lcdtc_pkg::BPP_LSB +: lcdtc_pkg::BPP_W]);

  assign cfg.enable      = voe;
  assign cfg.tft         = tft_mode;
  assign cfg.toggle_sel  = ctrl1_reg[lcdtc_pkg::TSEL_BIT];
  assign cfg.toggle_val  = ctrl4_reg[lcdtc_pkg::TRV_LSB +: lcdtc_pkg::TRV_W];
  assign cfg.back_porch  = ctrl2_reg[lcdtc_pkg::VBP_LSB +: lcdtc_pkg::PORCH_W];
  assign cfg.front_porch = ctrl2_reg[lcdtc_pkg::VFP_LSB +: lcdtc_pkg::PORCH_W];
  assign cfg.sync_width  = ctrl2_reg[lcdtc_pkg::VSW_LSB +: lcdtc_pkg::VSW_W];
  assign cfg.line_count  = ctrl2_reg[lcdtc_pkg::VLC_LSB +: lcdtc_pkg::LCNT_W];

  // ******************************************************
  // pixel clock and line timing
  // ******************************************************
  lcdtc_pixdiv #(
    .DW (lcdtc_pkg::CDIV_W)
  ) u_pixdiv (
    .pclk        (pclk),
    .presetn     (presetn),
    .enable      (voe),
    .tft         (tft_mode),
    .divider     (ctrl1_reg[lcdtc_pkg::CDIV_LSB +: lcdtc_pkg::CDIV_W]),
    .pixel_clock (pixel_clock),
    .pix_rise    (pix_rise)
  );

  lcdtc_vertical u_vertical (
    .pclk    (pclk),
    .presetn (presetn),
    .cfg     (cfg)
  );

  assign h_first = h_cnt_reg == 12'h000;
  assign h_last  = h_cnt_reg == (H_TOTAL - 12'h001);
  assign cfg.line_tick = pix_rise & h_last;
  assign vactive = cfg.vstate == lcdtc_pkg::VS_ACTIVE;
  assign stn_first = ~tft_mode & vactive & (cfg.line_counter == cfg.line_count);
  assign horiz_sampling_clock = pixel_clock;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      h_cnt_reg <= '0;
    end else if (!voe) begin
      h_cnt_reg <= '0;
    end else if (pix_rise) begin
      h_cnt_reg <= h_last ? 12'h000 : h_cnt_reg + 12'h001;
    end
  end

  // ******************************************************
  // panel outputs
  // ******************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      horiz_start_pulse    <= 1'b0;
      source_load_pulse    <= 1'b0;
      vertical_shift_clock <= 1'b0;
      vertical_start_pulse <= 1'b0;
      ac_bias_signal       <= 1'b0;
      video_data_enable    <= 1'b0;
      panel_power_pin      <= 1'b0;
    end else begin
      horiz_start_pulse    <= voe & vactive & h_first;
      source_load_pulse    <= voe & h_last;
      vertical_shift_clock <= voe & (h_cnt_reg < H_SHIFT);
      vertical_start_pulse <= voe & ((cfg.vstate == lcdtc_pkg::VS_SYNC) | stn_first);
      ac_bias_signal       <= voe & cfg.ac_bias;
      video_data_enable    <= voe & vactive & (h_cnt_reg < H_ACTIVE);
      panel_power_pin      <= (pwen & voe) ^ pwflip;
    end
  end

  // ******************************************************
  // checks
  // ******************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_power_on;
    wr_en && sel1 && pwdata[lcdtc_pkg::VOE_BIT] && pwen && !pwflip ##1 !(wr_en && sel5)
      |-> ##1 panel_power_pin;
  endproperty
  a_power_on: assert property (p_power_on) else $error("power pin not following enable");

  property p_power_flip;
    (!pwen && pwflip)[*2] |-> panel_power_pin;
  endproperty
  a_power_flip: assert property (p_power_flip) else $error("power pin polarity wrong");

  property p_quiet;
    (!voe)[*2] |-> !(video_data_enable | horiz_start_pulse | source_load_pulse
                     | vertical_start_pulse | pixel_clock | ac_bias_signal);
  endproperty
  a_quiet: assert property (p_quiet) else $error("panel active while disabled");

  property p_mode;
    !tft_mode |-> pixel_bits <= 5'h0C;
  endproperty
  a_mode: assert property (p_mode) else $error("stn depth out of range");

  c_enable: cover property (wr_en && sel1 && pwdata[lcdtc_pkg::VOE_BIT]);
  c_power:  cover property ($rose(panel_power_pin));
  c_vstart: cover property ($rose(vertical_start_pulse));
endmodule // lcdtc_panel_timing

// >>> logic/lcdtc_pixdiv.sv
// pixel clock divider running from the bus clock
`timescale 1ns/100ps
module lcdtc_pixdiv #(
  parameter int DW = 10
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          enable,
  input  wire logic          tft,
  input  wire logic [DW-1:0] divider,
  output logic               pixel_clock,
  output logic               pix_rise
);
  logic [DW:0] half;
  logic [DW:0] cnt_reg;
  logic        wrap;

  // half period: divider+1 on tft, divider on stn (floor of one)
  assign half = tft ? ({1'b0, divider} + {{DW{1'b0}}, 1'b1})
                    : ((divider == '0) ? {{DW{1'b0}}, 1'b1} : {1'b0, divider});
  assign wrap = (cnt_reg + {{DW{1'b0}}, 1'b1}) >= half;
  assign pix_rise = enable & wrap & ~pixel_clock;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      pixel_clock <= 1'b0;
    end else if (!enable) begin
      cnt_reg <= '0;
      pixel_clock <= 1'b0;
    end else if (wrap) begin
      cnt_reg <= '0;
      pixel_clock <= ~pixel_clock;
    end else begin
      cnt_reg <= cnt_reg + {{DW{1'b0}}, 1'b1};
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_stn_div;
    enable && !tft && divider >= 2 && $stable(divider) && $stable(tft) && wrap
      |-> cnt_reg == {1'b0, divider} - 1;
  endproperty
  a_stn_div: assert property (p_stn_div) else $error("stn half period wrong");

  property p_tft_div;
    enable && tft && $stable(divider) && $stable(tft) && wrap |-> cnt_reg == {1'b0, divider};
  endproperty
  a_tft_div: assert property (p_tft_div) else $error("tft half period wrong");
endmodule // lcdtc_pixdiv

// >>> logic/lcdtc_pkg.sv
// constants, field layout and types of the lcd panel timing control block
package lcdtc_pkg;
  // ******************************************************
  // register map
  // ******************************************************
  localparam logic [31:0] ADDR_CTRL1  = 32'h4D000000;
  localparam logic [31:0] ADDR_CTRL2  = 32'h4D000004;
  localparam logic [31:0] ADDR_CTRL4  = 32'h4D00000C;
  localparam logic [31:0] ADDR_CTRL5  = 32'h4D000010;
  localparam logic [31:0] RESET_WORD  = 32'h00000000;
  localparam logic [31:0] CTRL1_WMASK = 32'h0003FFFF;
  localparam logic [31:0] CTRL4_WMASK = 32'h0000FF00;
  localparam logic [31:0] CTRL5_WMASK = 32'h00000028;
  // ******************************************************
  // field positions
  // ******************************************************
  localparam int LCNT_LSB = 18;
  localparam int LCNT_W   = 10;
  localparam int CDIV_LSB = 8;
  localparam int CDIV_W   = 10;
  localparam int TSEL_BIT = 7;
  localparam int PTYP_LSB = 5;
  localparam int PTYP_W   = 2;
  localparam int BPP_LSB  = 1;
  localparam int BPP_W    = 4;
  localparam int VOE_BIT  = 0;
  localparam int VBP_LSB  = 24;
  localparam int VLC_LSB  = 14;
  localparam int VFP_LSB  = 6;
  localparam int PORCH_W  = 8;
  localparam int VSW_LSB  = 0;
  localparam int VSW_W    = 6;
  localparam int TRV_LSB  = 8;
  localparam int TRV_W    = 8;
  localparam int PWEN_BIT = 3;
  localparam int PWFL_BIT = 5;
  localparam logic [1:0] PTYP_TFT = 2'h3;
  // ******************************************************
  // types and decoding
  // ******************************************************
  typedef enum logic [1:0] {VS_SYNC, VS_BACK, VS_ACTIVE, VS_FRONT} lcdtc_vstate_e;

  // bits per pixel of a depth code, zero for unused codes
  function automatic logic [4:0] lcdtc_depth(input logic tft, input logic [3:0] code);
    logic [4:0] bits;
    bits = 5'h00;
    unique case ({tft, code})
      5'h00:   bits = 5'h01;
      5'h01:   bits = 5'h02;
      5'h02:   bits = 5'h04;
      5'h03:   bits = 5'h08;
      5'h04:   bits = 5'h0C;
      5'h18:   bits = 5'h01;
      5'h19:   bits = 5'h02;
      5'h1A:   bits = 5'h04;
      5'h1B:   bits = 5'h08;
      5'h1C:   bits = 5'h10;
      5'h1D:   bits = 5'h18;
      default: bits = 5'h00;
    endcase
    return bits;
  endfunction
endpackage

// >>> logic/lcdtc_vertical.sv
// vertical sequencer: sync, porches, active lines, line counter, ac bias
`timescale 1ns/100ps
module lcdtc_vertical (
  input  wire logic pclk,
  input  wire logic presetn,
  lcdtc_cfg_if.vert cfg
);
  lcdtc_pkg::lcdtc_vstate_e state_reg;
  lcdtc_pkg::lcdtc_vstate_e state_next;
  logic [10:0] cnt_reg;
  logic [10:0] len;
  logic [9:0]  line_reg;
  logic [7:0]  ac_cnt_reg;
  logic        ac_reg;
  logic        last;
  logic        frame_end;
  logic        ac_flip;

  // skip phases of zero length, as on stn panels
  function automatic lcdtc_pkg::lcdtc_vstate_e first_live(input lcdtc_pkg::lcdtc_vstate_e s,
      input logic [5:0] sw, input logic [7:0] bp, input logic [7:0] fp);
    lcdtc_pkg::lcdtc_vstate_e r;
    r = s;
    if (r == lcdtc_pkg::VS_FRONT && fp == '0) r = lcdtc_pkg::VS_SYNC;
    if (r == lcdtc_pkg::VS_SYNC && sw == '0) r = lcdtc_pkg::VS_BACK;
    if (r == lcdtc_pkg::VS_BACK && bp == '0) r = lcdtc_pkg::VS_ACTIVE;
    return r;
  endfunction

  // phase lengths in lines
  always_comb begin
    len = '0;
    unique case (state_reg)
      lcdtc_pkg::VS_SYNC:   len = {5'h00, cfg.sync_width};
      lcdtc_pkg::VS_BACK:   len = {3'h0, cfg.back_porch};
      lcdtc_pkg::VS_ACTIVE: len = {1'b0, cfg.line_count} + 11'h001;
      lcdtc_pkg::VS_FRONT:  len = {3'h0, cfg.front_porch};
    endcase
  end

  assign last = (cnt_reg + 11'h001) >= len;
  assign state_next = first_live(lcdtc_pkg::lcdtc_vstate_e'(state_reg + 2'h1),
                                 cfg.sync_width, cfg.back_porch, cfg.front_porch);
  assign frame_end = cfg.line_tick & last & (state_reg == lcdtc_pkg::VS_ACTIVE);
  assign ac_flip = cfg.toggle_sel ? (cfg.line_tick & (ac_cnt_reg >= cfg.toggle_val))
                                  : frame_end;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= lcdtc_pkg::VS_SYNC;
      cnt_reg <= '0;
    end else if (!cfg.enable) begin
      state_reg <= lcdtc_pkg::VS_SYNC;
      cnt_reg <= '0;
    end else if (cfg.line_tick) begin
      state_reg <= last ? state_next : state_reg;
      cnt_reg <= last ? 11'h000 : cnt_reg + 11'h001;
    end
  end

  // line counter: reload on entering the active phase, count down per active line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_reg <= '0;
    end else if (!cfg.enable) begin
      line_reg <= '0;
    end else if (cfg.line_tick && last && state_next == lcdtc_pkg::VS_ACTIVE) begin
      line_reg <= cfg.line_count;
    end else if (cfg.line_tick && state_reg == lcdtc_pkg::VS_ACTIVE && line_reg != '0) begin
      line_reg <= line_reg - 10'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ac_cnt_reg <= '0;
      ac_reg <= 1'b0;
    end else if (!cfg.enable) begin
      ac_cnt_reg <= '0;
      ac_reg <= 1'b0;
    end else begin
      ac_reg <= ac_reg ^ ac_flip;
      if (cfg.line_tick) begin
        ac_cnt_reg <= ac_flip ? 8'h00 : ac_cnt_reg + 8'h01;
      end
    end
  end

  assign cfg.vstate = state_reg;
  assign cfg.line_counter = line_reg;
  assign cfg.ac_bias = ac_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_line_down;
    cfg.enable && cfg.line_tick && state_reg == lcdtc_pkg::VS_ACTIVE && !last
      |=> line_reg == $past(line_reg) - 10'h001;
  endproperty
  a_line_down: assert property (p_line_down) else $error("line counter did not step");

  property p_reload;
    cfg.enable && $changed(state_reg) && state_reg == lcdtc_pkg::VS_ACTIVE
      && $stable(cfg.line_count) |-> line_reg == cfg.line_count;
  endproperty
  a_reload: assert property (p_reload) else $error("line counter not reloaded");

  property p_sync_len;
    state_reg == lcdtc_pkg::VS_SYNC && cfg.sync_width != '0 && $stable(cfg.sync_width)
      |-> cnt_reg < {5'h00, cfg.sync_width};
  endproperty
  a_sync_len: assert property (p_sync_len) else $error("sync phase too long");

  property p_back_len;
    state_reg == lcdtc_pkg::VS_BACK && $stable(cfg.back_porch)
      |-> cnt_reg < {3'h0, cfg.back_porch};
  endproperty
  a_back_len: assert property (p_back_len) else $error("back porch too long");

  property p_front_len;
    state_reg == lcdtc_pkg::VS_FRONT && $stable(cfg.front_porch)
      |-> cnt_reg < {3'h0, cfg.front_porch};
  endproperty
  a_front_len: assert property (p_front_len) else $error("front porch too long");

  property p_ac_frame;
    cfg.enable && !cfg.toggle_sel && frame_end |=> ac_reg != $past(ac_reg);
  endproperty
  a_ac_frame: assert property (p_ac_frame) else $error("ac bias missed frame toggle");

  c_frame: cover property (frame_end);
  c_porch: cover property (state_reg == lcdtc_pkg::VS_FRONT ##1 state_reg == lcdtc_pkg::VS_SYNC);
endmodule // lcdtc_vertical

// >>> tb/lcdtc_panel_model.sv
// panel-side model measuring the timing seen at the panel pins
`timescale 1ns/100ps
module lcdtc_panel_model (
  input  wire logic pclk,
  input  wire logic pixel_clock,
  input  wire logic vertical_start_pulse,
  input  wire logic source_load_pulse,
  input  wire logic ac_bias_signal,
  output int        pix_per,
  output int        vs_per,
  output int        vs_high,
  output int        ac_per,
  output int        lines
);
  int   t = 0, t_pix = 0, t_vs = 0, t_ac = 0, nl = 0;
  logic pc_d = 1'b0, vs_d = 1'b0, sl_d = 1'b0, ac_d = 1'b0;
  // panel needs no timing logic of its own: it only samples the pins
  always @(posedge pclk) begin
    t <= t + 1;
    pc_d <= pixel_clock;
    vs_d <= vertical_start_pulse;
    sl_d <= source_load_pulse;
    ac_d <= ac_bias_signal;
    if (pixel_clock && !pc_d) begin
      pix_per <= t - t_pix;
      t_pix <= t;
    end
    if (vertical_start_pulse && !vs_d) begin
      vs_per <= t - t_vs;
      t_vs <= t;
      lines <= nl;
      nl <= 0;
    end else if (source_load_pulse && !sl_d) begin
      nl <= nl + 1;
    end
    if (!vertical_start_pulse && vs_d) begin
      vs_high <= t - t_vs;
    end
    if (ac_bias_signal != ac_d) begin
      ac_per <= t - t_ac;
      t_ac <= t;
    end
  end
endmodule // lcdtc_panel_model

// >>> tb/test_lcd_panel_timing_control.sv
// self-checking testbench of the lcd panel timing control block
`timescale 1ns/100ps
module test_lcd_panel_timing_control;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h00000000, pwdata = 32'h00000000, prdata, r;
  logic        pready, pslverr, pixel_clock, horiz_sampling_clock, horiz_start_pulse;
  logic        source_load_pulse, vertical_shift_clock, vertical_start_pulse;
  logic        ac_bias_signal, video_data_enable, panel_power_pin, tft_mode, e, acc;
  logic [4:0]  pixel_bits, eb;
  logic [9:0]  mx;
  logic [4:0]  stn_b [5] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h0C};
  logic [4:0]  tft_b [8] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h18, 5'h00, 5'h00};
  int          n_mismatch = 0, compares = 0, pix_per, vs_per, vs_high, ac_per, lines;
  int          n_hs, n_vc, n_de, n_hc;
  always #4 pclk = ~pclk;
  lcdtc_panel_timing #(.H_ACTIVE(12'h004), .H_TOTAL(12'h006), .H_SHIFT(12'h003)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pixel_clock(pixel_clock), .horiz_sampling_clock(horiz_sampling_clock),
    .horiz_start_pulse(horiz_start_pulse), .source_load_pulse(source_load_pulse),
    .vertical_shift_clock(vertical_shift_clock), .vertical_start_pulse(vertical_start_pulse),
    .ac_bias_signal(ac_bias_signal), .video_data_enable(video_data_enable),
    .panel_power_pin(panel_power_pin), .tft_mode(tft_mode), .pixel_bits(pixel_bits));
  lcdtc_panel_model u_panel (
    .pclk(pclk), .pixel_clock(pixel_clock), .vertical_start_pulse(vertical_start_pulse),
    .source_load_pulse(source_load_pulse), .ac_bias_signal(ac_bias_signal),
    .pix_per(pix_per), .vs_per(vs_per), .vs_high(vs_high), .ac_per(ac_per), .lines(lines));
  // ******************************************************
  // tasks
  // ******************************************************
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_int(input int got, input int exp);
    compares++;
    if (got != exp) begin
      n_mismatch++;
      $display("unexpected at %0t: measured %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      n_mismatch++;
      end_of_test();
    end
  endtask
  // ******************************************************
  // tests
  // ******************************************************
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(lcdtc_pkg::ADDR_CTRL1, 1'b0, 32'h0);
    chk(r, lcdtc_pkg::RESET_WORD);
    apb(lcdtc_pkg::ADDR_CTRL2, 1'b0, 32'h0);
    chk(r, lcdtc_pkg::RESET_WORD);
    apb(lcdtc_pkg::ADDR_CTRL2, 1'b1, 32'hFFFFFFFF);
    apb(lcdtc_pkg::ADDR_CTRL2, 1'b0, 32'h0);
    chk(r, 32'hFFFFFFFF);
    apb(lcdtc_pkg::ADDR_CTRL1, 1'b1, 32'hFFFFFFFE);
    apb(lcdtc_pkg::ADDR_CTRL1, 1'b0, 32'h0);
    chk(r, 32'h0003FFFE);
    apb(32'h4D000008, 1'b0, 32'h0);
    chk({e, r[30:0]}, 32'h80000000);
    $display("test registers done");
    for (int i = 0; i < 64; i++) begin
      apb(lcdtc_pkg::ADDR_CTRL1, 1'b1, 32'(i) << 1);
      @(posedge pclk);
      if (i[5:4] == 2'h3) eb = i[3] ? tft_b[i[2:0]] : 5'h00;
      else eb = (i[3:0] < 5) ? stn_b[i[2:0]] : 5'h00;
      chk({26'h0, tft_mode, pixel_bits}, {26'h0, i[5:4] == 2'h3, eb});
    end
    $display("test modes done");
    for (int i = 0; i < 8; i++) begin
      apb(lcdtc_pkg::ADDR_CTRL5, 1'b1, {26'h0, i[1], 1'b0, i[0], 3'h0});
      apb(lcdtc_pkg::ADDR_CTRL1, 1'b1, {31'h30, i[2]});
      repeat (2) @(posedge pclk);
      chk({31'h0, panel_power_pin}, {31'h0, (i[0] & i[2]) ^ i[1]});
    end
    $display("test power done");
    apb(lcdtc_pkg::ADDR_CTRL2, 1'b1, 32'h0);
    apb(lcdtc_pkg::ADDR_CTRL1, 1'b1, 32'h00000261);
    repeat (100) @(posedge pclk);
    chk_int(pix_per, 6);
    apb(lcdtc_pkg::ADDR_CTRL1, 1'b1, 32'h00000201);
    repeat (100) @(posedge pclk);
    chk_int(pix_per, 4);
    apb(lcdtc_pkg::ADDR_CTRL1, 1'b1, 32'h0);
    @(posedge pclk);
    acc = 1'b0;
    repeat (40) begin
      @(posedge pclk);
      acc = acc | pixel_clock | video_data_enable | vertical_start_pulse | ac_bias_signal;
    end
    chk({31'h0, acc}, 32'h0);
    $display("test pixel clock done");
    apb(lcdtc_pkg::ADDR_CTRL2, 1'b1, 32'h01008042);
    apb(lcdtc_pkg::ADDR_CTRL1, 1'b1, 32'h00000061);
    repeat (400) @(posedge pclk);
    chk_int(vs_per, 84);
    chk_int(vs_high, 24);
    chk_int(lines, 7);
    chk_int(ac_per, 84);
    mx = 10'h000;
    acc = 1'b0;
    repeat (30) begin
      apb(lcdtc_pkg::ADDR_CTRL1, 1'b0, 32'h0);
      acc = acc | (r[27:18] > 10'h002);
      if (r[27:18] > mx) mx = r[27:18];
    end
    chk({21'h0, acc, mx}, 32'h00000002);
    n_hs = 0;
    n_vc = 0;
    n_de = 0;
    n_hc = 0;
    repeat (84) begin
      @(posedge pclk);
      n_hs += horiz_start_pulse;
      n_vc += vertical_shift_clock;
      n_de += video_data_enable;
      n_hc += horiz_sampling_clock;
    end
    chk_int(n_hs, 6);
    chk_int(n_vc, 42);
    chk_int(n_de, 24);
    chk_int(n_hc, 42);
    $display("test tft frame done");
    apb(lcdtc_pkg::ADDR_CTRL1, 1'b1, 32'h0);
    apb(lcdtc_pkg::ADDR_CTRL2, 1'b1, 32'h00008000);
    apb(lcdtc_pkg::ADDR_CTRL4, 1'b1, 32'h0);
    apb(lcdtc_pkg::ADDR_CTRL1, 1'b1, 32'h00000181);
    repeat (300) @(posedge pclk);
    chk_int(ac_per, 12);
    chk_int(vs_per, 36);
    apb(lcdtc_pkg::ADDR_CTRL2, 1'b1, 32'h00008000);
    repeat (100) @(posedge pclk);
    chk_int(vs_per, 36);
    $display("test stn frame done");
    end_of_test();
  end
endmodule // test_lcd_panel_timing_control
